// ===== design/iosc_top.sv
// Slot status block: encoder counters, speed, digital and frequency and analog status
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module iosc_top #(
	parameter int WIN_CYCLES = iosc_pkg::WIN_CYC,
	parameter int GATE_CYCLES = iosc_pkg::GATE_CYC,
	parameter int AIN_COUNT = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input iosc_pkg::iosc_wb_req_s wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat_o,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic zero_done,
	input wire logic [5:0] input_pins,
	input wire logic freq_in_a,
	input wire logic freq_in_b,
	input wire logic [15:0] analog_in_a,
	input wire logic [15:0] analog_in_b,
	input wire logic [15:0] analog_in_c,
	output logic output_bit_0,
	output logic output_bit_1,
	output logic [15:0] freq_out_a,
	output logic [15:0] freq_out_b,
	output logic signed [15:0] analog_out_a,
	output logic signed [15:0] analog_out_b
);
	import iosc_pkg::*;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic signed [15:0] sat_pct(input logic signed [31:0] v);
		if (v > PCT_FULL) begin
			return 16'(PCT_FULL);
		end else if (v < -PCT_FULL) begin
			return 16'(-PCT_FULL);
		end
		return 16'(v);
	endfunction

	function automatic logic [15:0] pct_to_hz(input logic signed [15:0] p);
		logic [31:0] mag;
		mag = (p < 0) ? 32'(-32'(p)) : 32'(p);
		return 16'((mag * HZ_FULL) / PCT_FULL);
	endfunction

	function automatic logic signed [15:0] hz_to_pct(input logic [15:0] hz);
		return 16'((32'(hz) * PCT_FULL) / HZ_FULL);
	endfunction

	function automatic logic signed [15:0] ain_scale(input logic [15:0] raw, input logic [15:0] lo,
		input logic [15:0] hi);
		logic signed [31:0] d;
		if (hi <= lo) begin
			return 16'h0000;
		end
		d = 32'(raw) - 32'(lo);
		return sat_pct((d * PCT_FULL) / $signed(32'(hi - lo)));
	endfunction

	function automatic logic signed [31:0] rpm_of(input logic signed [17:0] cnt,
		input logic [15:0] ppr);
		logic [31:0] mag;
		mag = (cnt < 0) ? 32'(-32'(cnt)) : 32'(cnt);
		mag = (mag * RPM_PER_PPMS) / 32'(ppr);
		if (mag > RPM_MAX) begin
			mag = RPM_MAX;
		end
		return (cnt < 0) ? -$signed(mag) : $signed(mag);
	endfunction

	// Two-flop synchronisers for the digital, encoder and frequency input pins
	logic [9:0] pin_s1_reg;
	logic [9:0] pin_s2_reg;
	logic [9:0] pin_s3_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_s1_reg <= 10'h000;
			pin_s2_reg <= 10'h000;
			pin_s3_reg <= 10'h000;
		end else begin
			pin_s1_reg <= {freq_in_b, freq_in_a, enc_b, enc_a, input_pins};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	logic [5:0] input_bit_vector;
	logic enc_pulse;
	logic enc_fwd;
	logic fia_edge;
	logic fib_edge;

	assign input_bit_vector = pin_s2_reg[5:0];
	// One count per rising edge of channel A; B low at that edge means forward
	assign enc_pulse = pin_s2_reg[6] & ~pin_s3_reg[6];
	assign enc_fwd = ~pin_s2_reg[7];
	assign fia_edge = pin_s2_reg[8] & ~pin_s3_reg[8];
	assign fib_edge = pin_s2_reg[9] & ~pin_s3_reg[9];

	// Software-visible configuration
	logic [3:0] ctrl_reg;
	logic [15:0] ppr_reg;
	logic [1:0] dout_reg;
	logic [15:0] ain_min_reg;
	logic [15:0] ain_max_reg;
	logic signed [15:0] cmd_reg [CMD_NUM];
	logic [15:0] ppr_eff;
	logic wr_en;
	logic [2:0] cmd_idx;
	logic cmd_hit;

	assign ppr_eff = (ppr_reg == 16'h0000) ? 16'h0001 : ppr_reg;
	assign wr_en = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack;
	assign cmd_idx = 3'((wb_req.adr - OFS_CMD_BASE) >> 2);
	assign cmd_hit = (wb_req.adr >= OFS_CMD_BASE) && (wb_req.adr <= OFS_CMD_LAST) &&
		(wb_req.adr[1:0] == 2'b00);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RST;
			ppr_reg <= PPR_RST;
			dout_reg <= DOUT_RST;
			ain_min_reg <= AIN_MIN_RST;
			ain_max_reg <= AIN_MAX_RST;
		end else if (wr_en) begin
			unique case (wb_req.adr)
				OFS_CTRL: ctrl_reg <= 4'(merge_bytes(32'(ctrl_reg), wb_req.dat, wb_req.sel));
				OFS_PPR: ppr_reg <= 16'(merge_bytes(32'(ppr_reg), wb_req.dat, wb_req.sel));
				OFS_DOUT: dout_reg <= 2'(merge_bytes(32'(dout_reg), wb_req.dat, wb_req.sel));
				OFS_AIN_MIN: ain_min_reg <= 16'(merge_bytes(32'(ain_min_reg), wb_req.dat,
					wb_req.sel));
				OFS_AIN_MAX: ain_max_reg <= 16'(merge_bytes(32'(ain_max_reg), wb_req.dat,
					wb_req.sel));
				default: ;
			endcase
		end
	end

	// Network and plc percent commands, clamped to +/-100.00 on write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < CMD_NUM; i++) begin
				cmd_reg[i] <= 16'sh0000;
			end
		end else if (wr_en && cmd_hit) begin
			cmd_reg[cmd_idx] <= sat_pct($signed(merge_bytes(32'(cmd_reg[cmd_idx]), wb_req.dat,
				wb_req.sel)));
		end
	end

	// Applied values: each frequency and analog output follows its plc or network command
	logic signed [15:0] foa_pct;
	logic signed [15:0] fob_pct;

	assign foa_pct = ctrl_reg[CTRL_FOA_PLC] ? cmd_reg[CMD_FOA_PLC] : cmd_reg[CMD_FOA_NET];
	assign fob_pct = ctrl_reg[CTRL_FOB_PLC] ? cmd_reg[CMD_FOB_PLC] : cmd_reg[CMD_FOB_NET];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			freq_out_a <= 16'h0000;
			freq_out_b <= 16'h0000;
			analog_out_a <= 16'sh0000;
			analog_out_b <= 16'sh0000;
			output_bit_0 <= 1'b0;
			output_bit_1 <= 1'b0;
		end else begin
			freq_out_a <= pct_to_hz(foa_pct);
			freq_out_b <= pct_to_hz(fob_pct);
			analog_out_a <= ctrl_reg[CTRL_AOA_PLC] ? cmd_reg[CMD_AOA_PLC] : cmd_reg[CMD_AOA_NET];
			analog_out_b <= ctrl_reg[CTRL_AOB_PLC] ? cmd_reg[CMD_AOB_PLC] : cmd_reg[CMD_AOB_NET];
			output_bit_0 <= dout_reg[0];
			output_bit_1 <= dout_reg[1];
		end
	end

	// Position: residual pulse count and whole revolutions
	logic [15:0] pulse_cnt_reg;
	logic [15:0] rev_reg;
	logic [15:0] frac_reg;

	always_ff @(posedge clk) begin
		if (!rst_n || zero_done) begin
			pulse_cnt_reg <= 16'h0000;
			rev_reg <= 16'h0000;
		end else if (enc_pulse && enc_fwd) begin
			if (pulse_cnt_reg >= ppr_eff - 16'h0001) begin
				pulse_cnt_reg <= 16'h0000;
				rev_reg <= rev_reg + 16'h0001;
			end else begin
				pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
			end
		end else if (enc_pulse) begin
			if (pulse_cnt_reg == 16'h0000) begin
				pulse_cnt_reg <= ppr_eff - 16'h0001;
				rev_reg <= rev_reg - 16'h0001;
			end else begin
				pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frac_reg <= 16'h0000;
		end else begin
			frac_reg <= 16'((32'(pulse_cnt_reg) * FRAC_SCALE) / 32'(ppr_eff));
		end
	end

	// Speed: signed pulse count over a 1 ms window, converted at its end
	logic [31:0] win_cnt_reg;
	logic win_end;
	logic signed [17:0] win_pulses_reg;
	logic signed [31:0] speed_reg;

	assign win_end = (win_cnt_reg == 32'(WIN_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			win_cnt_reg <= 32'h00000000;
		end else begin
			win_cnt_reg <= win_end ? 32'h00000000 : win_cnt_reg + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			win_pulses_reg <= 18'sh00000;
		end else if (win_end) begin
			win_pulses_reg <= !enc_pulse ? 18'sh00000 : (enc_fwd ? 18'sh00001 : 18'sh3FFFF);
		end else if (enc_pulse) begin
			win_pulses_reg <= enc_fwd ? win_pulses_reg + 18'sh00001 : win_pulses_reg - 18'sh00001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			speed_reg <= 32'sh00000000;
		end else if (win_end) begin
			speed_reg <= rpm_of(win_pulses_reg, ppr_eff);
		end
	end

	// Frequency inputs: rising edges counted over a gate time
	logic [31:0] gate_cnt_reg;
	logic gate_end;
	logic [15:0] fia_cnt_reg;
	logic [15:0] fib_cnt_reg;
	logic [15:0] fia_hz_reg;
	logic [15:0] fib_hz_reg;

	assign gate_end = (gate_cnt_reg == 32'(GATE_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_cnt_reg <= 32'h00000000;
		end else begin
			gate_cnt_reg <= gate_end ? 32'h00000000 : gate_cnt_reg + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fia_cnt_reg <= 16'h0000;
			fib_cnt_reg <= 16'h0000;
		end else if (gate_end) begin
			fia_cnt_reg <= {15'h0000, fia_edge};
			fib_cnt_reg <= {15'h0000, fib_edge};
		end else begin
			if (fia_edge && fia_cnt_reg < 16'(HZ_FULL)) begin
				fia_cnt_reg <= fia_cnt_reg + 16'h0001;
			end
			if (fib_edge && fib_cnt_reg < 16'(HZ_FULL)) begin
				fib_cnt_reg <= fib_cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fia_hz_reg <= 16'h0000;
			fib_hz_reg <= 16'h0000;
		end else if (gate_end) begin
			fia_hz_reg <= fia_cnt_reg;
			fib_hz_reg <= fib_cnt_reg;
		end
	end

	// Analog inputs scaled between configured minimum and maximum
	logic signed [15:0] aia_pct_reg;
	logic signed [15:0] aib_pct_reg;
	logic signed [15:0] aic_pct_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aia_pct_reg <= 16'sh0000;
			aib_pct_reg <= 16'sh0000;
			aic_pct_reg <= 16'sh0000;
		end else begin
			aia_pct_reg <= ain_scale(analog_in_a, ain_min_reg, ain_max_reg);
			aib_pct_reg <= ain_scale(analog_in_b, ain_min_reg, ain_max_reg);
			// Third input exists only on the additional slots
			aic_pct_reg <= (AIN_COUNT > 2) ?
				ain_scale(analog_in_c, ain_min_reg, ain_max_reg) : 16'sh0000;
		end
	end

	// Wishbone slave: ack one cycle after the request, unmapped reads give zero
	logic [31:0] rd_next;

	always_comb begin
		rd_next = 32'h00000000;
		if (cmd_hit) begin
			rd_next = 32'(cmd_reg[cmd_idx]);
		end else begin
			unique case (wb_req.adr)
				OFS_CTRL: rd_next = 32'(ctrl_reg);
				OFS_PPR: rd_next = 32'(ppr_reg);
				OFS_DOUT: rd_next = 32'(dout_reg);
				OFS_AIN_MIN: rd_next = 32'(ain_min_reg);
				OFS_AIN_MAX: rd_next = 32'(ain_max_reg);
				OFS_REV: rd_next = 32'(rev_reg);
				OFS_FRAC: rd_next = 32'(frac_reg);
				OFS_SPEED: rd_next = speed_reg;
				OFS_DIN: rd_next = 32'(input_bit_vector);
				OFS_FIA_HZ: rd_next = 32'(fia_hz_reg);
				OFS_FIA_PCT: rd_next = 32'(hz_to_pct(fia_hz_reg));
				OFS_FIB_HZ: rd_next = 32'(fib_hz_reg);
				OFS_FIB_PCT: rd_next = 32'(hz_to_pct(fib_hz_reg));
				OFS_FOA_HZ: rd_next = 32'(freq_out_a);
				OFS_FOA_PCT: rd_next = 32'(foa_pct);
				OFS_FOB_HZ: rd_next = 32'(freq_out_b);
				OFS_FOB_PCT: rd_next = 32'(fob_pct);
				OFS_AIA_PCT: rd_next = 32'(aia_pct_reg);
				OFS_AIB_PCT: rd_next = 32'(aib_pct_reg);
				OFS_AIC_PCT: rd_next = 32'(aic_pct_reg);
				OFS_AOA_PCT: rd_next = 32'(analog_out_a);
				OFS_AOB_PCT: rd_next = 32'(analog_out_b);
				default: rd_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ack <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack <= wb_req.cyc & wb_req.stb & ~wb_ack;
			wb_dat_o <= rd_next;
		end
	end

	// Checks
	default clocking iosc_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_count_powerup: assert property (disable iff (1'b0) !rst_n |=> rev_reg == 16'h0000 && pulse_cnt_reg == 16'h0000) else $error("counters not cleared by reset");
	a_zero_clear: assert property (zero_done |=> rev_reg == 16'h0000 && pulse_cnt_reg == 16'h0000) else $error("zero search did not clear counters");
	a_rev_carry: assert property (!zero_done && enc_pulse && enc_fwd && pulse_cnt_reg == ppr_eff - 16'h0001 |=> rev_reg == $past(rev_reg) + 16'h0001 && pulse_cnt_reg == 16'h0000) else $error("forward carry wrong");
	a_rev_borrow: assert property (!zero_done && enc_pulse && !enc_fwd && pulse_cnt_reg == 16'h0000 |=> rev_reg == $past(rev_reg) - 16'h0001) else $error("reverse borrow wrong");
	a_frac_step: assert property (!zero_done && enc_pulse && enc_fwd && pulse_cnt_reg < ppr_eff - 16'h0001 |=> pulse_cnt_reg == $past(pulse_cnt_reg) + 16'h0001) else $error("forward pulse not counted");
	a_frac_value: assert property ($stable(pulse_cnt_reg) && $stable(ppr_eff) |-> frac_reg == 16'((32'(pulse_cnt_reg) * FRAC_SCALE) / 32'(ppr_eff))) else $error("fraction scale wrong");
	a_speed_hold: assert property (!$past(win_end) |-> $stable(speed_reg)) else $error("speed changed inside window");
	a_speed_range: assert property (speed_reg <= RPM_MAX && speed_reg >= -RPM_MAX) else $error("speed out of range");
	a_speed_sign: assert property (win_end && win_pulses_reg > 0 |=> speed_reg > 0) else $error("forward speed not positive");
	a_din_map: assert property (input_bit_vector == $past(pin_s1_reg[5:0])) else $error("input vector wrong");
	a_dout_map: assert property ({output_bit_1, output_bit_0} == $past(dout_reg)) else $error("output bits wrong");
	a_fin_range: assert property (fia_hz_reg <= 16'(HZ_FULL) && fib_hz_reg <= 16'(HZ_FULL)) else $error("input frequency out of range");
	a_ao_range: assert property (analog_out_a <= PCT_FULL && analog_out_a >= -PCT_FULL) else $error("analog output out of range");
	a_ack_single: assert property (wb_ack |=> !wb_ack) else $error("ack held two cycles");

	c_fwd_carry: cover property (enc_pulse && enc_fwd && pulse_cnt_reg == ppr_eff - 16'h0001);
	c_rev_borrow: cover property (enc_pulse && !enc_fwd && pulse_cnt_reg == 16'h0000);
	c_speed_new: cover property (win_end && win_pulses_reg != 18'sh00000);
	c_bus_write: cover property (wr_en && cmd_hit);
endmodule

// ===== pkg/iosc_pkg.sv
// Shared constants, register map and bus carrier for the slot status encoder block
package iosc_pkg;
	// Timing: clock period, speed window and frequency gate
	localparam int CLK_NS = 20;
	localparam int WIN_NS = 1000000;
	localparam int WIN_CYC = WIN_NS / CLK_NS;
	localparam int GATE_NS = 1000000000;
	localparam int GATE_CYC = GATE_NS / CLK_NS;
	// Scales: percent in hundredths, frequency full scale, speed limit
	localparam int PCT_FULL = 10000;
	localparam int HZ_FULL = 32000;
	localparam int RPM_MAX = 60000;
	localparam int RPM_PER_PPMS = 60000;
	localparam int FRAC_SCALE = 65536;
	// Reset values
	localparam logic [15:0] PPR_RST = 16'h0400;
	localparam logic [15:0] AIN_MIN_RST = 16'h0000;
	localparam logic [15:0] AIN_MAX_RST = 16'hFFFF;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [1:0] DOUT_RST = 2'h0;
	// Control field positions: 1 selects the plc command, 0 the network one
	localparam int CTRL_FOA_PLC = 0;
	localparam int CTRL_FOB_PLC = 1;
	localparam int CTRL_AOA_PLC = 2;
	localparam int CTRL_AOB_PLC = 3;
	// Byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PPR = 8'h04;
	localparam logic [7:0] OFS_DOUT = 8'h08;
	localparam logic [7:0] OFS_AIN_MIN = 8'h0C;
	localparam logic [7:0] OFS_AIN_MAX = 8'h10;
	localparam logic [7:0] OFS_CMD_BASE = 8'h14;
	localparam logic [7:0] OFS_CMD_LAST = 8'h30;
	localparam logic [7:0] OFS_REV = 8'h40;
	localparam logic [7:0] OFS_FRAC = 8'h44;
	localparam logic [7:0] OFS_SPEED = 8'h48;
	localparam logic [7:0] OFS_DIN = 8'h4C;
	localparam logic [7:0] OFS_FIA_HZ = 8'h50;
	localparam logic [7:0] OFS_FIA_PCT = 8'h54;
	localparam logic [7:0] OFS_FIB_HZ = 8'h58;
	localparam logic [7:0] OFS_FIB_PCT = 8'h5C;
	localparam logic [7:0] OFS_FOA_HZ = 8'h60;
	localparam logic [7:0] OFS_FOA_PCT = 8'h64;
	localparam logic [7:0] OFS_FOB_HZ = 8'h68;
	localparam logic [7:0] OFS_FOB_PCT = 8'h6C;
	localparam logic [7:0] OFS_AIA_PCT = 8'h70;
	localparam logic [7:0] OFS_AIB_PCT = 8'h74;
	localparam logic [7:0] OFS_AIC_PCT = 8'h78;
	localparam logic [7:0] OFS_AOA_PCT = 8'h7C;
	localparam logic [7:0] OFS_AOB_PCT = 8'h80;
	// Command slots, index = (offset - OFS_CMD_BASE) / 4
	localparam int CMD_FOA_NET = 0;
	localparam int CMD_FOA_PLC = 1;
	localparam int CMD_FOB_NET = 2;
	localparam int CMD_FOB_PLC = 3;
	localparam int CMD_AOA_NET = 4;
	localparam int CMD_AOA_PLC = 5;
	localparam int CMD_AOB_NET = 6;
	localparam int CMD_AOB_PLC = 7;
	localparam int CMD_NUM = 8;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} iosc_wb_req_s;
endpackage

// ===== testbench/iosc_partner.sv
// Behavioural quadrature encoder that also feeds both frequency input pins
`timescale 1ns/100ps
module iosc_partner (
	input wire logic clk,
	input wire logic start,
	input wire logic rev,
	input wire logic [15:0] count,
	input wire logic [7:0] half,
	output logic enc_a,
	output logic enc_b,
	output logic busy
);
	task automatic step(input logic a, input logic b);
		enc_a <= a;
		enc_b <= b;
		repeat (half) @(posedge clk);
	endtask
	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (start) begin
				busy <= 1'b1;
				for (int i = 0; i < count; i++) begin
					// Forward: a rises while b is low; reverse: b leads, a rises while b is high
					step(~rev, rev);
					step(1'b1, 1'b1);
					step(rev, ~rev);
					step(1'b0, 1'b0);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule

// ===== testbench/test_io_slot_status_encoder_counter.sv
// Self-checking bench for the slot status encoder block
`timescale 1ns/100ps
module test_io_slot_status_encoder_counter;
	import iosc_pkg::*;
	localparam int WIN = 100;
	localparam int GATE = 200;
	localparam int AMIN = 1000;
	localparam int AMAX = 3000;
	logic clk;
	logic rst_n;
	iosc_wb_req_s wb_req;
	logic wb_ack;
	logic [31:0] wb_dat_o;
	logic enc_a;
	logic enc_b;
	logic zero_done;
	logic [5:0] input_pins;
	logic [15:0] ain [3];
	logic output_bit_0;
	logic output_bit_1;
	logic [15:0] freq_out_a;
	logic [15:0] freq_out_b;
	logic signed [15:0] analog_out_a;
	logic signed [15:0] analog_out_b;
	logic p_start;
	logic p_rev;
	logic [15:0] p_count;
	logic [7:0] p_half;
	logic p_busy;
	logic [31:0] seed;
	logic [31:0] rd;
	logic [3:0] ctrl;
	int cmd [8];
	int pos;
	int err_count;
	int tests_run;

	iosc_top #(.WIN_CYCLES(WIN), .GATE_CYCLES(GATE), .AIN_COUNT(3)) dut (
		.clk(clk), .rst_n(rst_n), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
		.enc_a(enc_a), .enc_b(enc_b), .zero_done(zero_done), .input_pins(input_pins),
		.freq_in_a(enc_a), .freq_in_b(enc_b), .analog_in_a(ain[0]), .analog_in_b(ain[1]),
		.analog_in_c(ain[2]), .output_bit_0(output_bit_0), .output_bit_1(output_bit_1),
		.freq_out_a(freq_out_a), .freq_out_b(freq_out_b), .analog_out_a(analog_out_a),
		.analog_out_b(analog_out_b)
	);
	iosc_partner enc (
		.clk(clk), .start(p_start), .rev(p_rev), .count(p_count), .half(p_half),
		.enc_a(enc_a), .enc_b(enc_b), .busy(p_busy)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] rev_exp(int p, int ppr);
		int q;
		q = p / ppr;
		if (p % ppr < 0) q--;
		return {16'h0000, 16'(q)};
	endfunction
	function automatic logic [31:0] frac_exp(int p, int ppr);
		int r;
		r = p % ppr;
		if (r < 0) r += ppr;
		return 32'(r * FRAC_SCALE / ppr);
	endfunction
	function automatic logic [31:0] speed_exp(int per_win, int ppr, logic rev);
		int v;
		v = per_win * RPM_PER_PPMS / ppr;
		if (v > RPM_MAX) v = RPM_MAX;
		return rev ? 32'(-v) : 32'(v);
	endfunction
	function automatic int clamp(int v);
		return (v > PCT_FULL) ? PCT_FULL : ((v < -PCT_FULL) ? -PCT_FULL : v);
	endfunction
	function automatic int applied(int b);
		return ctrl[b] ? cmd[2 * b + 1] : cmd[2 * b];
	endfunction
	function automatic logic [31:0] hz_of(int p);
		return 32'(((p < 0) ? -p : p) * HZ_FULL / PCT_FULL);
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) check("wb_ack", 32'h0, 32'h1);
		rd = wb_dat_o;
		wb_req <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_cycle(1'b1, adr, dat);
	endtask
	task automatic rdc(input string name, input logic [7:0] adr, input logic [31:0] exp);
		wb_cycle(1'b0, adr, 32'h0);
		check(name, rd, exp);
	endtask
	task automatic kick(input logic rev, input int n, input int half);
		p_rev <= rev;
		p_count <= 16'(n);
		p_half <= 8'(half);
		p_start <= 1'b1;
		pos = rev ? pos - n : pos + n;
		@(posedge clk);
		p_start <= 1'b0;
		@(posedge clk);
	endtask
	task automatic finish_run();
		int t;
		t = 0;
		while (p_busy === 1'b1 && t < 20000) begin
			@(posedge clk);
			t++;
		end
		if (t >= 20000) check("partner_done", 32'h0, 32'h1);
		repeat (8) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		summarize();
	end

	initial begin
		seed = 32'h000100D2;
		err_count = 0;
		tests_run = 0;
		pos = 0;
		rst_n = 1'b0;
		wb_req = '0;
		zero_done = 1'b0;
		input_pins = 6'h00;
		ain = '{16'h0000, 16'h0000, 16'h0000};
		p_start = 1'b0;
		p_rev = 1'b0;
		p_count = 16'h0000;
		p_half = 8'h02;
		ctrl = 4'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc("rev_rst", OFS_REV, 32'h0);
		rdc("frac_rst", OFS_FRAC, 32'h0);
		rdc("ppr_rst", OFS_PPR, {16'h0000, PPR_RST});
		rdc("ain_max_rst", OFS_AIN_MAX, {16'h0000, AIN_MAX_RST});
		wr(OFS_REV, 32'h00001234);
		rdc("rev_ro", OFS_REV, 32'h0);
		rdc("unmapped", 8'hFC, 32'h0);
		// Whole and partial turns, then clear and borrow below zero
		wr(OFS_PPR, 32'h4);
		kick(1'b0, 14, 2);
		finish_run();
		rdc("rev_fwd", OFS_REV, rev_exp(pos, 4));
		rdc("frac_fwd", OFS_FRAC, frac_exp(pos, 4));
		kick(1'b1, 3, 2);
		finish_run();
		rdc("rev_back", OFS_REV, rev_exp(pos, 4));
		rdc("frac_back", OFS_FRAC, frac_exp(pos, 4));
		zero_done <= 1'b1;
		@(posedge clk);
		zero_done <= 1'b0;
		pos = 0;
		@(posedge clk);
		rdc("rev_zero", OFS_REV, 32'h0);
		rdc("frac_zero", OFS_FRAC, 32'h0);
		kick(1'b1, 1, 2);
		finish_run();
		rdc("rev_borrow", OFS_REV, rev_exp(pos, 4));
		rdc("frac_borrow", OFS_FRAC, frac_exp(pos, 4));
		// Steady runs: one pulse each 20 cycles gives 5 per window, 10 per gate
		wr(OFS_PPR, 32'h3E8);
		kick(1'b0, 80, 5);
		repeat (700) @(posedge clk);
		for (int w = 0; w < 3; w++) begin
			rdc("speed_fwd", OFS_SPEED, speed_exp(5, 1000, 1'b0));
			repeat (WIN) @(posedge clk);
		end
		rdc("fia_hz", OFS_FIA_HZ, 32'hA);
		rdc("fia_pct", OFS_FIA_PCT, 32'(10 * PCT_FULL / HZ_FULL));
		rdc("fib_hz", OFS_FIB_HZ, 32'hA);
		rdc("fib_pct", OFS_FIB_PCT, 32'(10 * PCT_FULL / HZ_FULL));
		finish_run();
		repeat (2 * WIN) @(posedge clk);
		rdc("speed_idle", OFS_SPEED, 32'h0);
		kick(1'b1, 80, 5);
		repeat (700) @(posedge clk);
		rdc("speed_rev", OFS_SPEED, speed_exp(5, 1000, 1'b1));
		finish_run();
		wr(OFS_PPR, 32'h4);
		kick(1'b0, 80, 5);
		repeat (700) @(posedge clk);
		rdc("speed_clamp", OFS_SPEED, speed_exp(5, 4, 1'b0));
		finish_run();
		// Digital inputs and outputs
		for (int i = 0; i < 4; i++) begin
			logic [5:0] v;
			logic [1:0] d;
			v = (i == 0) ? 6'h3F : 6'(rnd());
			d = (i == 0) ? 2'h3 : 2'(rnd());
			input_pins <= v;
			repeat (4) @(posedge clk);
			rdc("din", OFS_DIN, {26'h0, v});
			wr(OFS_DOUT, {30'h0, d});
			repeat (2) @(posedge clk);
			check("dout_0", {31'h0, output_bit_0}, {31'h0, d[0]});
			check("dout_1", {31'h0, output_bit_1}, {31'h0, d[1]});
		end
		// Network and plc commands under every source selection
		for (int k = 0; k < 4; k++) begin
			ctrl = (k == 0) ? 4'h0 : ((k == 1) ? 4'hF : ((k == 2) ? 4'h5 : 4'hA));
			wr(OFS_CTRL, {28'h0, ctrl});
			for (int j = 0; j < CMD_NUM; j++) begin
				int r;
				r = int'(rnd() % 24001) - 12000;
				cmd[j] = clamp(r);
				wr(OFS_CMD_BASE + 8'(4 * j), 32'(r));
				rdc("cmd", OFS_CMD_BASE + 8'(4 * j), 32'(cmd[j]));
			end
			repeat (2) @(posedge clk);
			check("foa_hz", {16'h0, freq_out_a}, hz_of(applied(CTRL_FOA_PLC)));
			check("fob_hz", {16'h0, freq_out_b}, hz_of(applied(CTRL_FOB_PLC)));
			rdc("foa_hz_reg", OFS_FOA_HZ, hz_of(applied(CTRL_FOA_PLC)));
			rdc("foa_pct", OFS_FOA_PCT, 32'(applied(CTRL_FOA_PLC)));
			rdc("fob_pct", OFS_FOB_PCT, 32'(applied(CTRL_FOB_PLC)));
			check("aoa", 32'(analog_out_a), 32'(applied(CTRL_AOA_PLC)));
			check("aob", 32'(analog_out_b), 32'(applied(CTRL_AOB_PLC)));
			rdc("aoa_pct", OFS_AOA_PCT, 32'(applied(CTRL_AOA_PLC)));
			rdc("aob_pct", OFS_AOB_PCT, 32'(applied(CTRL_AOB_PLC)));
		end
		// Analog inputs scaled between the configured limits
		wr(OFS_AIN_MIN, 32'(AMIN));
		wr(OFS_AIN_MAX, 32'(AMAX));
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 3; c++) begin
				ain[c] <= (i == 0) ? 16'(AMIN + c * 1000) : 16'(AMIN + rnd() % 2001);
			end
			repeat (3) @(posedge clk);
			for (int c = 0; c < 3; c++) begin
				rdc("ain_pct", OFS_AIA_PCT + 8'(4 * c),
					32'((ain[c] - AMIN) * PCT_FULL / (AMAX - AMIN)));
			end
		end
		summarize();
	end
endmodule
